//--- hdl/cotf_cfg.svh
// constants of the close-onto-fault guard: offsets, fields, resets, timing
// assumes a 50 MHz pclk and an APB master with 12-bit byte addresses
//
// Function
// - window arms only on arm input rising edge, held level never re-arms
// - any fault input during running window trips at once, no delay
// - window length equals release time, 0 to 1800 s, default 1 s
// - block input prevents window start; blocked edge gives no active, trip
// - separate blocked, active and trip outputs
// - forced state 0 normal 1 blocked 2 active 3 trip, only when enabled
// - read-only state code 0 normal 1 init 2 active 3 trip 4 blocked
// - ON and OFF events for init, block, active, trip, masked per event
// - each event carries time stamp and process values
// - circular log of last twelve entries, written on active ON
// - entry: time, event id, setting group, remaining and active time
// - release time chosen per setting group for later arming
// - decisions use binary inputs only, no analog values
`ifndef COTF_CFG_SVH
`define COTF_CFG_SVH

// timing
`define COTF_CLK_HZ 50000000
`define COTF_TICK_US 1000
`define COTF_REL_MAX_MS 21'h1B7740
`define COTF_REL_DEF_MS 21'h0003E8
`define COTF_LOG_DEPTH 12
`define COTF_NUM_SG 8

// register byte offsets
`define COTF_A_CTRL 12'h000
`define COTF_A_STATUS 12'h004
`define COTF_A_EVMASK 12'h008
`define COTF_A_TIME 12'h00C
`define COTF_A_REMAIN 12'h010
`define COTF_A_ELAPSED 12'h014
`define COTF_A_LOGSEL 12'h018
`define COTF_A_LOGTS 12'h01C
`define COTF_A_LOGINFO 12'h020
`define COTF_A_LOGREM 12'h024
`define COTF_A_LOGACT 12'h028
`define COTF_A_REL_BASE 12'h040
`define COTF_A_REL_LAST 12'h05C

// fields and reset values
`define COTF_CTRL_FEN 0
`define COTF_CTRL_FSEL 1
`define COTF_EVMASK_RST 8'hFF
`define COTF_EV_INIT 0
`define COTF_EV_BLOCK 1
`define COTF_EV_ACTIVE 2
`define COTF_EV_TRIP 3
`define COTF_LOGID_ACT_ON 4'h2

// state readout codes
`define COTF_CODE_NORMAL 3'h0
`define COTF_CODE_INIT 3'h1
`define COTF_CODE_ACTIVE 3'h2
`define COTF_CODE_TRIP 3'h3
`define COTF_CODE_BLOCKED 3'h4

// forced state codes
`define COTF_FRC_NORMAL 2'h0
`define COTF_FRC_BLOCKED 2'h1
`define COTF_FRC_ACTIVE 2'h2
`define COTF_FRC_TRIP 2'h3

`endif

//--- hdl/cotf_pkg.sv
// types shared by the close-onto-fault guard files
// assumes nothing beyond a SystemVerilog compiler
`default_nettype none
package cotf_pkg;
   typedef enum logic [4:0] {
      ST_NORMAL = 5'h01,
      ST_INIT = 5'h02,
      ST_ACTIVE = 5'h04,
      ST_TRIP = 5'h08,
      ST_BLOCKED = 5'h10
   } cotf_state_t;

   typedef logic [20:0] cotf_ms_t;

   // event strobes with the process values captured with them
   typedef struct packed {
      logic [7:0] hit;
      logic [31:0] stamp;
      logic [2:0] sg;
      cotf_ms_t remain;
      cotf_ms_t elapsed;
   } cotf_event_t;

   typedef struct packed {
      logic valid;
      logic [31:0] stamp;
      logic [3:0] id;
      logic [2:0] sg;
      cotf_ms_t remain;
      cotf_ms_t elapsed;
   } cotf_log_t;

   typedef struct packed {
      logic [1:0] fsel;
      logic force_en;
   } cotf_ctrl_t;
endpackage
`default_nettype wire

//--- hdl/cotf_win_timer.sv
// release window timer: millisecond prescaler and down counter
// assumes start and abort are single-cycle synchronous pulses or levels
`default_nettype none
module cotf_win_timer #(
   parameter int TICK_CYCLES = 50000,
   parameter int TW = 21
) (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // control
   input wire logic start,
   input wire logic abort,
   input wire logic [TW-1:0] len,
   // status
   output logic running,
   output logic [TW-1:0] remain,
   output logic [TW-1:0] elapsed,
   output logic expire
);
   localparam int PW = $clog2(TICK_CYCLES + 1);
   logic [PW-1:0] pre_q, pre_d;
   logic [TW-1:0] rem_q, rem_d, ela_q, ela_d;
   logic run_q, run_d, exp_q, exp_d;

   // prescaler restarts with the window so its length is exact
   always_comb begin
      pre_d = pre_q;
      rem_d = rem_q;
      ela_d = ela_q;
      run_d = run_q;
      exp_d = 1'b0;
      if (abort) begin
         run_d = 1'b0;
      end else if (start) begin
         pre_d = '0;
         rem_d = len;
         ela_d = '0;
         run_d = (len != '0);
         exp_d = (len == '0);
      end else if (run_q) begin
         if (pre_q == PW'(TICK_CYCLES - 1)) begin
            pre_d = '0;
            rem_d = rem_q - TW'(1);
            ela_d = ela_q + TW'(1);
            if (rem_q == TW'(1)) begin
               run_d = 1'b0;
               exp_d = 1'b1;
            end
         end else begin
            pre_d = pre_q + PW'(1);
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pre_q <= '0;
         rem_q <= '0;
         ela_q <= '0;
         run_q <= 1'b0;
         exp_q <= 1'b0;
      end else begin
         pre_q <= pre_d;
         rem_q <= rem_d;
         ela_q <= ela_d;
         run_q <= run_d;
         exp_q <= exp_d;
      end
   end

   assign running = run_q;
   assign remain = rem_q;
   assign elapsed = ela_q;
   assign expire = exp_q;
endmodule // cotf_win_timer
`default_nettype wire

//--- hdl/cotf_log_mem.sv
// small log memory, one write port and a registered read port
// assumes indices below DEPTH; contents are not reset
`default_nettype none
module cotf_log_mem #(
   parameter int DEPTH = 12,
   parameter int W = 82
) (
   // clock
   input wire logic pclk,
   // write side
   input wire logic wr_en,
   input wire logic [$clog2(DEPTH)-1:0] wr_idx,
   input wire logic [W-1:0] wr_data,
   // read side
   input wire logic [$clog2(DEPTH)-1:0] rd_idx,
   output logic [W-1:0] rd_data
);
   logic [W-1:0] mem [DEPTH];
   logic [W-1:0] rd_q;

   // read data lags the index by one cycle
   always_ff @(posedge pclk) begin
      if (wr_en) begin
         mem[wr_idx] <= wr_data;
      end
      rd_q <= mem[rd_idx];
   end

   assign rd_data = rd_q;
endmodule // cotf_log_mem
`default_nettype wire

//--- hdl/cotf_guard.sv
// close-onto-fault guard: arming, trip, state, events, log, APB registers
// assumes all guard inputs are synchronous to pclk, APB from a single master
`include "cotf_cfg.svh"
`default_nettype none
module cotf_guard #(
   parameter int N_FUNC = 8,
   parameter int TICK_CYCLES = `COTF_CLK_HZ / 1000000 * `COTF_TICK_US,
   parameter int LOG_DEPTH = `COTF_LOG_DEPTH
) (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // guard inputs
   input wire logic arm_input,
   input wire logic block_input,
   input wire logic [N_FUNC-1:0] fault_input,
   input wire logic [2:0] setting_group_in_use,
   // guard outputs
   output logic blocked_out,
   output logic active_out,
   output logic trip_out,
   output logic [2:0] guard_state_readout,
   output cotf_pkg::cotf_event_t guard_event_block
);
   localparam int LW = $clog2(LOG_DEPTH);
   localparam int EW = $bits(cotf_pkg::cotf_log_t);

   logic arm_q, arm_d;
   logic arm_rise, win_start, win_run, win_exp, any_fault, trip_raw;
   cotf_pkg::cotf_ms_t win_rem, win_ela;
   cotf_pkg::cotf_state_t st_q, st_d;
   cotf_pkg::cotf_ctrl_t ctl_q, ctl_d;
   logic [7:0] mask_q, mask_d;
   cotf_pkg::cotf_ms_t rel_q [`COTF_NUM_SG];
   cotf_pkg::cotf_ms_t rel_d [`COTF_NUM_SG];
   logic [31:0] time_q, time_d;
   logic [$clog2(TICK_CYCLES+1)-1:0] tp_q, tp_d;
   logic [3:0] cond, prev_q, prev_d;
   cotf_pkg::cotf_event_t evt_q, evt_d;
   logic [LW-1:0] wptr_q, wptr_d, sel_q, sel_d, rd_idx;
   logic [LW:0] cnt_q, cnt_d;
   logic [LW:0] idx_sum;
   logic log_wr;
   cotf_pkg::cotf_log_t log_new, log_rd;
   logic [EW-1:0] log_raw;
   logic wr_acc, rd_acc, hit_ok;
   logic [31:0] rdata;

   // arming edge; a held level never restarts the window
   assign arm_d = arm_input;
   assign arm_rise = arm_input & ~arm_q;
   assign win_start = arm_rise & ~block_input;
   // only binary levels feed the decisions
   assign any_fault = |fault_input;
   assign trip_raw = win_run & any_fault;

   // length taken from the group in use at the arming edge
   cotf_win_timer #(
      .TICK_CYCLES(TICK_CYCLES),
      .TW(21)
   ) u_timer (
      .pclk(pclk),
      .presetn(presetn),
      .start(win_start),
      .abort(block_input),
      .len(rel_q[setting_group_in_use]),
      .running(win_run),
      .remain(win_rem),
      .elapsed(win_ela),
      .expire(win_exp)
   );

   // state readout, blocked has priority over everything
   always_comb begin
      if (block_input) begin
         st_d = cotf_pkg::ST_BLOCKED;
      end else if (trip_raw) begin
         st_d = cotf_pkg::ST_TRIP;
      end else if (win_run) begin
         st_d = cotf_pkg::ST_ACTIVE;
      end else if (arm_input) begin
         st_d = cotf_pkg::ST_INIT;
      end else begin
         st_d = cotf_pkg::ST_NORMAL;
      end
   end

   // state encoding to software code
   always_comb begin
      case (st_q)
         cotf_pkg::ST_INIT: guard_state_readout = `COTF_CODE_INIT;
         cotf_pkg::ST_ACTIVE: guard_state_readout = `COTF_CODE_ACTIVE;
         cotf_pkg::ST_TRIP: guard_state_readout = `COTF_CODE_TRIP;
         cotf_pkg::ST_BLOCKED: guard_state_readout = `COTF_CODE_BLOCKED;
         default: guard_state_readout = `COTF_CODE_NORMAL;
      endcase
   end

   // outputs; trip is combinational so it follows the fault at once
   always_comb begin
      blocked_out = block_input;
      active_out = win_run;
      trip_out = trip_raw;
      if (ctl_q.force_en) begin
         blocked_out = (ctl_q.fsel == `COTF_FRC_BLOCKED);
         active_out = (ctl_q.fsel == `COTF_FRC_ACTIVE);
         trip_out = (ctl_q.fsel == `COTF_FRC_TRIP);
      end
   end

   // event edges from the visible conditions
   always_comb begin
      cond = '0;
      cond[`COTF_EV_INIT] = arm_input;
      cond[`COTF_EV_BLOCK] = blocked_out;
      cond[`COTF_EV_ACTIVE] = active_out;
      cond[`COTF_EV_TRIP] = trip_out;
      prev_d = cond;
      evt_d.hit = {~cond & prev_q, cond & ~prev_q} & mask_q;
      evt_d.stamp = time_q;
      evt_d.sg = setting_group_in_use;
      evt_d.remain = win_rem;
      evt_d.elapsed = win_ela;
   end

   // log written on active ON regardless of the event mask
   always_comb begin
      log_wr = cond[`COTF_EV_ACTIVE] & ~prev_q[`COTF_EV_ACTIVE];
      log_new.valid = 1'b1;
      log_new.stamp = time_q;
      log_new.id = `COTF_LOGID_ACT_ON;
      log_new.sg = setting_group_in_use;
      log_new.remain = win_rem;
      log_new.elapsed = win_ela;
      wptr_d = wptr_q;
      cnt_d = cnt_q;
      if (log_wr) begin
         // circular: oldest entry overwritten after twelve
         if (wptr_q == LW'(LOG_DEPTH - 1)) begin
            wptr_d = '0;
         end else begin
            wptr_d = wptr_q + LW'(1);
         end
         if (cnt_q != (LW+1)'(LOG_DEPTH)) begin
            cnt_d = cnt_q + (LW+1)'(1);
         end
      end
   end

   // selector 0 is the newest entry
   always_comb begin
      idx_sum = {1'b0, wptr_q} + (LW+1)'(LOG_DEPTH - 1) - {1'b0, sel_q};
      if (idx_sum >= (LW+1)'(LOG_DEPTH)) begin
         idx_sum = idx_sum - (LW+1)'(LOG_DEPTH);
      end
      rd_idx = idx_sum[LW-1:0];
   end

   cotf_log_mem #(
      .DEPTH(LOG_DEPTH),
      .W(EW)
   ) u_log (
      .pclk(pclk),
      .wr_en(log_wr),
      .wr_idx(wptr_q),
      .wr_data(log_new),
      .rd_idx(rd_idx),
      .rd_data(log_raw)
   );

   // entries never written read as zero
   assign log_rd = ({1'b0, sel_q} < cnt_q) ? log_raw : '0;

   // free-running millisecond stamp, software may preset it
   always_comb begin
      tp_d = tp_q + ($bits(tp_q))'(1);
      time_d = time_q;
      if (tp_q == ($bits(tp_q))'(TICK_CYCLES - 1)) begin
         tp_d = '0;
         time_d = time_q + 32'h0000_0001;
      end
      if (wr_acc && paddr == `COTF_A_TIME) begin
         tp_d = '0;
         time_d = pwdata;
      end
   end

   // apb decode; every access finishes in its first access cycle
   assign wr_acc = psel & penable & pwrite;
   assign rd_acc = psel & penable & ~pwrite;
   assign pready = 1'b1;
   assign pslverr = psel & penable & ~hit_ok;
   assign prdata = rd_acc ? rdata : 32'h0000_0000;

   always_comb begin
      hit_ok = 1'b1;
      rdata = 32'h0000_0000;
      if (paddr == `COTF_A_CTRL) begin
         rdata[2:0] = ctl_q;
      end else if (paddr == `COTF_A_STATUS) begin
         rdata[2:0] = guard_state_readout;
         rdata[5:3] = {trip_out, active_out, blocked_out};
         rdata[10:8] = setting_group_in_use;
      end else if (paddr == `COTF_A_EVMASK) begin
         rdata[7:0] = mask_q;
      end else if (paddr == `COTF_A_TIME) begin
         rdata = time_q;
      end else if (paddr == `COTF_A_REMAIN) begin
         rdata[20:0] = win_rem;
      end else if (paddr == `COTF_A_ELAPSED) begin
         rdata[20:0] = win_ela;
      end else if (paddr == `COTF_A_LOGSEL) begin
         rdata[LW-1:0] = sel_q;
         rdata[8+LW:8] = cnt_q;
      end else if (paddr == `COTF_A_LOGTS) begin
         rdata = log_rd.stamp;
      end else if (paddr == `COTF_A_LOGINFO) begin
         rdata[3:0] = log_rd.id;
         rdata[6:4] = log_rd.sg;
         rdata[31] = log_rd.valid;
      end else if (paddr == `COTF_A_LOGREM) begin
         rdata[20:0] = log_rd.remain;
      end else if (paddr == `COTF_A_LOGACT) begin
         rdata[20:0] = log_rd.elapsed;
      end else if (paddr >= `COTF_A_REL_BASE && paddr <= `COTF_A_REL_LAST
                   && paddr[1:0] == 2'h0) begin
         rdata[20:0] = rel_q[paddr[4:2]];
      end else begin
         hit_ok = 1'b0;
      end
   end

   // control, mask and log selector writes
   always_comb begin
      ctl_d = ctl_q;
      mask_d = mask_q;
      sel_d = sel_q;
      if (wr_acc && paddr == `COTF_A_CTRL) begin
         ctl_d = pwdata[2:0];
      end
      if (wr_acc && paddr == `COTF_A_EVMASK) begin
         mask_d = pwdata[7:0];
      end
      // out-of-range selector clamps to the oldest slot
      if (wr_acc && paddr == `COTF_A_LOGSEL) begin
         if (pwdata[31:0] < 32'(LOG_DEPTH)) begin
            sel_d = pwdata[LW-1:0];
         end else begin
            sel_d = LW'(LOG_DEPTH - 1);
         end
      end
   end

   // release time per setting group; writes above the range clamp
   for (genvar g = 0; g < `COTF_NUM_SG; g++) begin : g_rel
      always_comb begin
         rel_d[g] = rel_q[g];
         if (wr_acc && paddr == `COTF_A_REL_BASE + 12'(4 * g)) begin
            if (pwdata > 32'(`COTF_REL_MAX_MS)) begin
               rel_d[g] = `COTF_REL_MAX_MS;
            end else begin
               rel_d[g] = pwdata[20:0];
            end
         end
      end

      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            rel_q[g] <= `COTF_REL_DEF_MS;
         end else begin
            rel_q[g] <= rel_d[g];
         end
      end
   end

   // all remaining state
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         arm_q <= 1'b0;
         st_q <= cotf_pkg::ST_NORMAL;
         ctl_q <= '0;
         mask_q <= `COTF_EVMASK_RST;
         time_q <= 32'h0000_0000;
         tp_q <= '0;
         prev_q <= 4'h0;
         evt_q <= '0;
         wptr_q <= '0;
         cnt_q <= '0;
         sel_q <= '0;
      end else begin
         arm_q <= arm_d;
         st_q <= st_d;
         ctl_q <= ctl_d;
         mask_q <= mask_d;
         time_q <= time_d;
         tp_q <= tp_d;
         prev_q <= prev_d;
         evt_q <= evt_d;
         wptr_q <= wptr_d;
         cnt_q <= cnt_d;
         sel_q <= sel_d;
      end
   end

   assign guard_event_block = evt_q;
endmodule // cotf_guard
`default_nettype wire

//--- verif/cotf_far.sv
// far-side model: protection functions and breaker close command logic
// assumes bench requests change just after rising or falling pclk edges
`default_nettype none
module cotf_far #(
   parameter int N = 8
) (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // bench requests {group, block, arm, fault}; slow adds one cycle of lag
   input wire logic slow,
   input wire logic [N+4:0] req,
   // levels towards the guard
   output logic arm_input,
   output logic block_input,
   output logic [N-1:0] fault_input,
   output logic [2:0] setting_group_in_use
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [N+4:0] s1_q, s2_q;
   // levels leave flops on pclk, so each holds for whole cycles
   always_ff @(posedge pclk) begin
      s1_q <= req;
      s2_q <= s1_q;
   end
   // quiet during reset; slow mode answers one cycle later
   assign {setting_group_in_use, block_input, arm_input, fault_input} =
      !presetn ? '0 : (slow ? s2_q : s1_q);
endmodule // cotf_far
`default_nettype wire

//--- verif/cotf_chk.sv
// checker of the close-onto-fault guard outputs against their causes
// assumes bind onto cotf_guard; force setting shadowed from apb writes
`default_nettype none
module cotf_chk #(
   parameter int N_FUNC = 8
) (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   // guard
   input wire logic arm_input,
   input wire logic block_input,
   input wire logic [N_FUNC-1:0] fault_input,
   input wire logic blocked_out,
   input wire logic active_out,
   input wire logic trip_out,
   input wire logic [2:0] guard_state_readout,
   input wire cotf_pkg::cotf_event_t guard_event_block
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [2:0] frc_q, frc_d;
   wire frc = frc_q[0];
   // shadow of the control word; no wait states, so the access edge counts
   always_comb begin
      frc_d = frc_q;
      if (psel && penable && pwrite && paddr == 12'h000)
         frc_d = pwdata[2:0];
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         frc_q <= 3'h0;
      else
         frc_q <= frc_d;
   end
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   AST_ARM_RISE: assert property (
      !frc && $rose(active_out) |-> $past(arm_input) && !$past(arm_input, 2))
      else $error("window opened without an arm edge");
   AST_NO_REARM: assert property (
      !frc && arm_input && $past(arm_input) && !active_out |=>
      !active_out || frc) else $error("held arm level opened a window");
   AST_TRIP: assert property (
      !frc |-> trip_out == (active_out && |fault_input))
      else $error("trip differs from window and fault");
   AST_BLK_OUT: assert property (
      !frc |-> blocked_out == block_input) else $error("blocked flag wrong");
   AST_BLOCK: assert property (
      !frc && block_input |=> !active_out || frc)
      else $error("window open while blocked");
   AST_FORCE_TRIP: assert property (
      frc && frc_q[2:1] == 2'h3 |-> trip_out) else $error("forced trip lost");
   AST_READ_TRIP: assert property (
      !frc && active_out && |fault_input && !block_input |=>
      guard_state_readout == 3'h3) else $error("readout not trip");
   AST_EXPIRE: assert property (
      !frc && $fell(active_out) && !block_input && !$past(block_input) |->
      ##[0:2] guard_state_readout <= 3'h1) else $error("no return to normal");
   AST_EV_ON: assert property (
      $rose(active_out) |=> guard_event_block.hit[2])
      else $error("active on event missing");
   AST_EV_OFF: assert property (
      $fell(trip_out) |=> guard_event_block.hit[7])
      else $error("trip off event missing");
endmodule // cotf_chk
bind cotf_guard cotf_chk #(.N_FUNC(N_FUNC)) u_chk (.pclk, .presetn, .psel,
   .penable, .pwrite, .paddr, .pwdata, .arm_input, .block_input,
   .fault_input, .blocked_out, .active_out, .trip_out,
   .guard_state_readout, .guard_event_block);
`default_nettype wire

//--- verif/tb.sv
// bench of the close-onto-fault guard: apb tasks, random arming, checks
// assumes guard, checker bind and far-side model are compiled beforehand
`include "cotf_cfg.svh"
`default_nettype none
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int TK = 4;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic slow = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, rd, v, x = 32'h0ECD;
   logic pready, pslverr, er, arm_input, block_input;
   logic blocked_out, active_out, trip_out, p;
   logic [7:0] fault_input;
   logic [2:0] setting_group_in_use, guard_state_readout;
   logic [12:0] req = 13'h0000; // {group, block, arm, fault}
   logic [20:0] len [8];
   cotf_pkg::cotf_event_t guard_event_block;
   int error_cnt = 0;
   int compares = 0;
   int arms = 0;
   // 50 MHz
   always #10 pclk = ~pclk;
   // one ms is TK cycles so windows stay short
   cotf_guard #(.TICK_CYCLES(TK)) dut (.pclk, .presetn, .psel, .penable,
      .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .arm_input,
      .block_input, .fault_input, .setting_group_in_use, .blocked_out,
      .active_out, .trip_out, .guard_state_readout, .guard_event_block);
   cotf_far u_far (.pclk, .presetn, .slow, .req, .arm_input, .block_input,
      .fault_input, .setting_group_in_use);
   function automatic logic [31:0] xs();
      x = x ^ (x << 13);
      x = x ^ (x >> 17);
      x = x ^ (x << 5);
      return x;
   endfunction
   // release time as held after a write: anything past the top clamps
   function automatic logic [31:0] clampv(input logic [31:0] w);
      return (w > 32'h001B7740) ? 32'h001B7740 : w;
   endfunction
   task automatic chk(input logic [31:0] g, input logic [31:0] e,
      input string m);
      compares++;
      if (g !== e) begin
         error_cnt++;
         $display("MISMATCH %0t %s", $time, m);
      end
   endtask
   task automatic conclude();
      $display("errors %0d compares %0d", error_cnt, compares);
      if (error_cnt == 0 && compares > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   // one transfer, entered just after an edge; one idle cycle after it
   task automatic apb(input logic w, input logic [11:0] a,
      input logic [31:0] d);
      int n;
      n = 0;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 16);
      rd = prdata;
      er = pslverr;
      chk(32'(n < 16), 32'h1, "apb wait");
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   // arm once in group g, fault after k active cycles; arm held past end
   task automatic window(input logic [2:0] g, input int k);
      int c;
      int t;
      c = 0;
      t = 0;
      p = 1'b0;
      req[12:10] <= g;
      repeat (3) @(posedge pclk);
      req[8] <= 1'b1;
      while (active_out !== 1'b1 && t < 8) begin
         @(negedge pclk);
         t++;
      end
      while (active_out === 1'b1 && c < 40) begin
         if (c == k)
            req[7:0] <= 8'(xs()) | 8'h01;
         chk(32'(trip_out), 32'(|fault_input), "trip");
         if (c >= 2)
            chk(32'(guard_state_readout), p ? 32'h3 : 32'h2, "st");
         p = trip_out;
         c++;
         @(negedge pclk);
      end
      chk(32'(c), 32'(len[g]) * TK, "window length");
      repeat (6) begin
         @(negedge pclk);
         chk(32'(active_out), 32'h0, "held arm");
      end
      @(posedge pclk);
      req[8:0] <= 9'h000;
      repeat (3) @(posedge pclk);
      if (len[g] != 21'h0) begin
         arms++;
         apb(1'b1, `COTF_A_LOGSEL, 32'h0);
         apb(1'b0, `COTF_A_LOGINFO, 32'h0);
         chk(rd & 32'h8000007F, {1'b1, 24'h0, g, 4'h2}, "log id");
         apb(1'b0, `COTF_A_LOGREM, 32'h0);
         chk(rd, 32'(len[g]), "log remain");
         apb(1'b0, `COTF_A_LOGACT, 32'h0);
         chk(rd, 32'h0, "log elapsed");
         apb(1'b0, `COTF_A_LOGSEL, 32'h0);
         chk(32'(rd[12:8]), arms > 12 ? 32'hC : 32'(arms), "log n");
      end
   endtask
   initial begin
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      // reset values, an unmapped place, mask and release times
      apb(1'b0, `COTF_A_EVMASK, 32'h0);
      chk(rd, 32'h000000FF, "mask reset");
      v = xs() & 32'h000000FF;
      apb(1'b1, `COTF_A_EVMASK, v);
      apb(1'b0, `COTF_A_EVMASK, 32'h0);
      chk(rd, v, "mask");
      // the checker expects the active ON and trip OFF event bits to reach the block
      apb(1'b1, `COTF_A_EVMASK, 32'h000000FF);
      apb(1'b1, 12'h030, 32'h0);
      chk({31'h0, er}, 32'h1, "unmapped error");
      for (int g = 0; g < 8; g++) begin
         apb(1'b0, `COTF_A_REL_BASE + 12'(4 * g), 32'h0);
         chk(rd, 32'h000003E8, "release reset");
         v = xs();
         apb(1'b1, `COTF_A_REL_BASE + 12'(4 * g), v);
         apb(1'b0, `COTF_A_REL_BASE + 12'(4 * g), 32'h0);
         chk(rd, clampv(v), "release clamp");
         len[g] = (g == 0) ? 21'h0 : 21'(xs() % 6 + 1);
         apb(1'b1, `COTF_A_REL_BASE + 12'(4 * g), 32'(len[g]));
      end
      window(3'h0, 99); // zero length opens nothing
      for (int i = 0; i < 14; i++) begin
         slow <= i[0];
         window(3'(xs() % 7 + 1), int'(xs() % 24));
      end
      // arming while blocked, then unblocking with arm still high
      req[12:9] <= 4'h5;
      repeat (3) @(posedge pclk);
      req[8:0] <= 9'h110;
      repeat (8) begin
         @(negedge pclk);
         chk(32'({active_out, trip_out, blocked_out}), 32'h1, "blk");
      end
      chk(32'(guard_state_readout), 32'h4, "blocked state");
      apb(1'b0, `COTF_A_STATUS, 32'h0);
      chk(rd & 32'h0000073F, 32'h0000020C, "status");
      @(posedge pclk);
      req[9] <= 1'b0;
      repeat (6) begin
         @(negedge pclk);
         chk(32'(active_out), 32'h0, "no edge after block");
      end
      @(posedge pclk);
      req[8:0] <= 9'h000;
      repeat (3) @(posedge pclk);
      // a long window in group 2 cut short by the block input
      apb(1'b1, `COTF_A_REL_BASE + 12'h008, 32'h00000006);
      req[8] <= 1'b1;
      repeat (4) @(posedge pclk);
      @(negedge pclk);
      chk(32'(active_out), 32'h1, "armed again");
      @(posedge pclk);
      req[9] <= 1'b1;
      repeat (3) @(posedge pclk);
      @(negedge pclk);
      chk(32'(active_out), 32'h0, "block aborts");
      chk(32'(guard_state_readout), 32'h4, "aborted state");
      @(posedge pclk);
      req[9:8] <= 2'h0;
      repeat (3) @(posedge pclk);
      // forced states, then a setting without the enable
      for (int s = 0; s < 4; s++) begin
         apb(1'b1, `COTF_A_CTRL, 32'(s * 2 + 1));
         chk(32'({blocked_out, active_out, trip_out}),
            (s == 0) ? 32'h0 : 32'(4 >> (s - 1)), "forced");
      end
      apb(1'b1, `COTF_A_CTRL, 32'h6);
      chk(32'({blocked_out, active_out, trip_out}), 32'h0, "unforced");
      apb(1'b1, `COTF_A_CTRL, 32'h0);
      conclude();
   end
   // hang guard, far beyond the length of the sequence above
   initial begin
      repeat (20000) @(posedge pclk);
      chk(32'h0, 32'h1, "watchdog");
      conclude();
   end
endmodule // tb
`default_nettype wire
